// File: design/qsmr_pkg.sv
// package of constants and types for the mapped flash read engine
package qsmr_pkg;

  // -------------------------------------------------------------------
  // system bus encodings
  // -------------------------------------------------------------------
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;
  localparam logic [31:0] ADDR_STEP    = 32'h0000_0004;
  localparam int          WINDOW_BITS  = 20;   // one megabyte window

  // -------------------------------------------------------------------
  // link timing, in system clock cycles (200 MHz)
  // -------------------------------------------------------------------
  localparam logic [1:0]  DIV_LAST     = 2'h1; // half link period - 1
  localparam logic [2:0]  HS_CYCLES    = 3'h4; // end plus start handshake

  // -------------------------------------------------------------------
  // phase lengths in quad nibbles
  // -------------------------------------------------------------------
  localparam logic [4:0]  NIB_HI8      = 5'h02;
  localparam logic [4:0]  NIB_16       = 5'h04;
  localparam logic [4:0]  NIB_XIP      = 5'h02;
  localparam logic [4:0]  NIB_DUMMY    = 5'h04; // undriven dummy clocks
  localparam logic [4:0]  NIB_WORD     = 5'h08;
  localparam logic [4:0]  NIB_LAST     = 5'h01;

  // -------------------------------------------------------------------
  // fifo and fetch counts
  // -------------------------------------------------------------------
  localparam logic [1:0]  FIFO_LAST    = 2'h2; // highest entry index
  localparam logic [1:0]  WORDS_PREF   = 2'h3; // one returned, two ahead
  localparam logic [1:0]  WORDS_ONE    = 2'h1;

  // engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SELHI = 5'b00010,
    ST_HSK   = 5'b00100,
    ST_SHIFT = 5'b01000,
    ST_HOLD  = 5'b10000
  } qsmr_state_e;

  // link phases, one-hot
  typedef enum logic [3:0] {
    PH_ADDR_HI = 4'b0001,
    PH_ADDR_LO = 4'b0010,
    PH_DUMMY   = 4'b0100,
    PH_DATA    = 4'b1000
  } qsmr_phase_e;

  // address phase of a system bus transfer
  typedef struct packed {
    logic        sel;
    logic [1:0]  trans;
    logic        write;
    logic [2:0]  size;
    logic [31:0] addr;
  } qsmr_req_s;

endpackage

// File: design/qsmr_top.sv
// mapped flash read engine with transmit and receive dma request generation
`timescale 1ns/1ps

module qsmr_top
  import qsmr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        tx_empty_flag,
  input  wire logic        rx_full_flag,
  input  wire logic        tx_empty_dma_req_enable,
  input  wire logic        rx_full_dma_req_enable,
  output logic             tx_dma_req,
  output logic             rx_dma_req,
  input  wire logic        master_select_output,
  input  wire logic        mapped_access_enable,
  input  wire logic [11:0] flash_remap_base,
  input  wire logic        address_width_select,
  input  wire logic [7:0]  xip_activation_byte,
  input  wire logic [3:0]  select_high_time,
  output logic             mapped_access_busy,
  input  wire qsmr_req_s   bus_req,
  output logic             hready,
  output logic [31:0]      hrdata,
  output logic             flash_clk,
  output logic             slave_select_n,
  input  wire logic [3:0]  flash_io_in,
  output logic [3:0]       flash_io_out,
  output logic [3:0]       flash_io_oe
);

  // -------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------
  qsmr_state_e state_q;
  qsmr_phase_e phase_q;
  logic [1:0]  div_q;
  logic [4:0]  nib_q;
  logic [2:0]  hs_q;
  logic [4:0]  gap_q;
  logic        sclk_q;
  logic        ss_n_q;
  logic        ss_hold_q;
  logic [3:0]  oe_q;
  logic [31:0] sh_out_q;
  logic [31:0] sh_in_q;
  logic [1:0]  words_q;
  logic [31:0] fl_addr_q;
  logic        session_q;
  logic        busy_q;
  logic        en_q;
  logic [3:0]  io_meta_q;
  logic [3:0]  io_sync_q;
  logic        hready_q;
  logic [31:0] hrdata_q;
  logic        pend_q;
  logic        seq_ok_q;
  logic [31:0] exp_addr_q;
  logic [31:0] fifo_q [0:2];
  logic [1:0]  wp_q;
  logic [1:0]  rp_q;
  logic [1:0]  lvl_q;
  logic        tx_req_q;
  logic        rx_req_q;

  // -------------------------------------------------------------------
  // decode of the bus request
  // -------------------------------------------------------------------
  logic        acc;
  logic        is_word;
  logic        seq_hit;
  logic        fifo_hit;
  logic        seq_wait;
  logic        nonseq;
  logic [31:0] new_addr;
  logic        tick;
  logic        phase_end;
  logic        word_done;
  logic [31:0] word_val;
  logic [31:0] sh_in_d;
  logic        push;
  logic        pop;
  logic        restart;
  logic        ss_n_d;

  // reads only; writes to the area complete without effect
  assign acc      = bus_req.sel & bus_req.trans[1] & ~bus_req.write
                  & hready_q & mapped_access_enable;
  assign is_word  = bus_req.size == HSIZE_WORD;
  assign seq_hit  = acc & seq_ok_q & is_word
                  & (bus_req.addr == exp_addr_q);
  assign fifo_hit = seq_hit & (lvl_q != 2'h0);
  assign seq_wait = seq_hit & (lvl_q == 2'h0);
  assign nonseq   = acc & ~seq_hit;
  // window offset of the bus address placed on the remap base
  assign new_addr = {flash_remap_base,
                     bus_req.addr[WINDOW_BITS-1:0]};

  // link timing events
  assign tick      = div_q == DIV_LAST;
  assign phase_end = (state_q == ST_SHIFT) & tick & sclk_q
                   & (nib_q == NIB_LAST);
  assign word_done = phase_end & (phase_q == PH_DATA);
  // flash delivers the lowest byte first
  assign sh_in_d   = {sh_in_q[27:0], io_sync_q};
  assign word_val  = {sh_in_d[7:0], sh_in_d[15:8],
                      sh_in_d[23:16], sh_in_d[31:24]};
  assign push      = word_done & ~pend_q & ~nonseq;
  assign pop       = fifo_hit;
  assign restart   = (state_q == ST_HOLD) & pend_q & (lvl_q == 2'h0);

  // select: engine owns it while mapped, held off after disable
  assign ss_n_d = mapped_access_enable ? (state_q == ST_SELHI)
                : ((ss_hold_q | ~master_select_output)
                   & ~sclk_q & ~(|oe_q));  // wait for the link to park

  // -------------------------------------------------------------------
  // dma requests and pin synchroniser
  // -------------------------------------------------------------------
  // level requests drop one cycle after the register access clears the flag
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_req_q  <= 1'b0;
      rx_req_q  <= 1'b0;
      io_meta_q <= 4'h0;
      io_sync_q <= 4'h0;
    end else begin
      tx_req_q  <= tx_empty_flag & tx_empty_dma_req_enable;
      rx_req_q  <= rx_full_flag & rx_full_dma_req_enable;
      io_meta_q <= flash_io_in;
      io_sync_q <= io_meta_q;
    end
  end

  // -------------------------------------------------------------------
  // select ownership and busy
  // -------------------------------------------------------------------
  // after disable, select stays high until software drops its own bit,
  // so a stale software assert cannot re-select the flash
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      en_q      <= 1'b0;
      ss_hold_q <= 1'b0;
      ss_n_q    <= 1'b1;
      busy_q    <= 1'b0;
    end else begin
      en_q   <= mapped_access_enable;
      ss_n_q <= ss_n_d;
      // a parked frame is not busy; a stalling request is, from its edge
      busy_q <= (state_q != ST_IDLE && state_q != ST_HOLD) | pend_q
              | (acc & ~fifo_hit);
      if (en_q && !mapped_access_enable) begin
        ss_hold_q <= 1'b1;
      end else if (!master_select_output) begin
        ss_hold_q <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // link engine
  // -------------------------------------------------------------------
  // a disable lets a high clock half period finish so the flash never
  // sees a runt clock pulse on a disable
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q   <= ST_IDLE;
      phase_q   <= PH_ADDR_HI;
      div_q     <= 2'h0;
      nib_q     <= 5'h00;
      hs_q      <= 3'h0;
      gap_q     <= 5'h00;
      sclk_q    <= 1'b0;
      oe_q      <= 4'h0;
      sh_out_q  <= 32'h0000_0000;
      sh_in_q   <= 32'h0000_0000;
      words_q   <= 2'h0;
      fl_addr_q <= 32'h0000_0000;
      session_q <= 1'b0;
    end else if (!mapped_access_enable) begin
      div_q <= tick ? 2'h0 : div_q + 2'h1;
      if (!sclk_q || tick) begin
        state_q   <= ST_IDLE;
        sclk_q    <= 1'b0;
        oe_q      <= 4'h0;
        session_q <= 1'b0;
      end
    end else if (nonseq) begin
      // first read skips the gap: select is already low
      state_q   <= session_q ? ST_SELHI : ST_HSK;
      gap_q     <= {select_high_time, 1'b1};
      hs_q      <= HS_CYCLES;
      phase_q   <= PH_ADDR_HI;
      fl_addr_q <= new_addr;
      words_q   <= is_word ? WORDS_PREF : WORDS_ONE;
      sclk_q    <= 1'b0;
      oe_q      <= 4'h0;
      div_q     <= 2'h0;
    end else begin
      div_q <= tick ? 2'h0 : div_q + 2'h1;
      case (state_q)
        ST_SELHI: begin
          if (tick) begin
            gap_q <= gap_q - 5'h01;
            if (gap_q == 5'h00) begin
              state_q <= ST_HSK;
            end
          end
        end
        ST_HSK: begin
          hs_q <= hs_q - 3'h1;
          if (hs_q == 3'h0) begin
            state_q <= ST_SHIFT;
            div_q   <= 2'h0;
            case (phase_q)
              PH_ADDR_HI: begin
                session_q <= 1'b1;
                oe_q      <= 4'hF;
                if (address_width_select) begin
                  sh_out_q <= {fl_addr_q[31:16], 16'h0000};
                  nib_q    <= NIB_16;
                end else begin
                  sh_out_q <= {fl_addr_q[23:16], 24'h000000};
                  nib_q    <= NIB_HI8;
                end
              end
              PH_ADDR_LO: begin
                sh_out_q <= {fl_addr_q[15:0], 16'h0000};
                nib_q    <= NIB_16;
              end
              PH_DUMMY: begin
                sh_out_q <= {xip_activation_byte, 24'h000000};
                nib_q    <= NIB_XIP + NIB_DUMMY;
              end
              default: begin
                oe_q  <= 4'h0;
                nib_q <= NIB_WORD;
              end
            endcase
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            // the synchroniser lags by one half period, so the nibble seen
            // at the fall is the one that stood on the lines at the rise
            if (sclk_q) begin
              sh_in_q  <= sh_in_d;
              sh_out_q <= {sh_out_q[27:0], 4'h0};
              nib_q    <= nib_q - 5'h01;
              if (phase_q == PH_DUMMY && nib_q == NIB_DUMMY + NIB_LAST) begin
                oe_q <= 4'h0;   // release lines for turnaround
              end
              if (nib_q == NIB_LAST) begin
                hs_q    <= HS_CYCLES;
                state_q <= ST_HSK;
                case (phase_q)
                  PH_ADDR_HI: phase_q <= PH_ADDR_LO;
                  PH_ADDR_LO: phase_q <= PH_DUMMY;
                  PH_DUMMY:   phase_q <= PH_DATA;
                  default: begin
                    words_q <= words_q - 2'h1;
                    if (words_q == WORDS_ONE) begin
                      state_q <= ST_HOLD;
                    end
                  end
                endcase
              end
            end
          end
        end
        ST_HOLD: begin
          // select stays low; the flash resumes the stream on more clocks
          if (restart) begin
            state_q <= ST_HSK;
            hs_q    <= HS_CYCLES;
            phase_q <= PH_DATA;
            words_q <= WORDS_PREF;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // bus answer and prefetch fifo
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hready_q   <= 1'b1;
      hrdata_q   <= 32'h0000_0000;
      pend_q     <= 1'b0;
      seq_ok_q   <= 1'b0;
      exp_addr_q <= 32'h0000_0000;
      wp_q       <= 2'h0;
      rp_q       <= 2'h0;
      lvl_q      <= 2'h0;
    end else if (!mapped_access_enable) begin
      // a stalled read is completed with zero rather than hanging the bus
      hready_q <= 1'b1;
      pend_q   <= 1'b0;
      seq_ok_q <= 1'b0;
      wp_q     <= 2'h0;
      rp_q     <= 2'h0;
      lvl_q    <= 2'h0;
      if (pend_q) begin
        hrdata_q <= 32'h0000_0000;
      end
    end else if (nonseq) begin
      hready_q   <= 1'b0;
      pend_q     <= 1'b1;
      seq_ok_q   <= is_word;
      exp_addr_q <= bus_req.addr + ADDR_STEP;
      wp_q       <= 2'h0;
      rp_q       <= 2'h0;
      lvl_q      <= 2'h0;
    end else begin
      if (seq_hit) begin
        exp_addr_q <= exp_addr_q + ADDR_STEP;
      end
      if (seq_wait) begin
        hready_q <= 1'b0;
        pend_q   <= 1'b1;
      end else if (fifo_hit) begin
        hrdata_q <= fifo_q[rp_q];
      end else if (word_done && pend_q) begin
        hrdata_q <= word_val;
        hready_q <= 1'b1;
        pend_q   <= 1'b0;
      end
      if (push) begin
        wp_q <= (wp_q == FIFO_LAST) ? 2'h0 : wp_q + 2'h1;
      end
      if (pop) begin
        rp_q <= (rp_q == FIFO_LAST) ? 2'h0 : rp_q + 2'h1;
      end
      lvl_q <= lvl_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // fifo entries, written by index
  always_ff @(posedge sys_clk) begin
    if (push && mapped_access_enable) begin
      fifo_q[wp_q] <= word_val;
    end
  end

  // -------------------------------------------------------------------
  // outputs straight from flops
  // -------------------------------------------------------------------
  assign tx_dma_req         = tx_req_q;
  assign rx_dma_req         = rx_req_q;
  assign mapped_access_busy = busy_q;
  assign hready             = hready_q;
  assign hrdata             = hrdata_q;
  assign flash_clk          = sclk_q;
  assign slave_select_n     = ss_n_q;
  assign flash_io_out       = sh_out_q[31:28];
  assign flash_io_oe        = oe_q;

endmodule // qsmr_top

// File: dv/qsmr_monitor.sv
// port checker for the mapped flash read engine
`timescale 1ns/1ps

module qsmr_monitor
  import qsmr_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       tx_empty_flag,
  input wire logic       rx_full_flag,
  input wire logic       tx_empty_dma_req_enable,
  input wire logic       rx_full_dma_req_enable,
  input wire logic       tx_dma_req,
  input wire logic       rx_dma_req,
  input wire logic       mapped_access_enable,
  input wire logic       mapped_access_busy,
  input wire qsmr_req_s  bus_req,
  input wire logic       hready,
  input wire logic       flash_clk,
  input wire logic       slave_select_n,
  input wire logic [3:0] flash_io_oe,
  input wire logic [3:0] select_high_time
);
  // ------------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------------
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // read accepted while mapped mode is on
  sequence s_taken;
    bus_req.sel && bus_req.trans[1] && !bus_req.write && hready &&
      mapped_access_enable;
  endsequence

  // shortest select-high gap: two half periods of two cycles
  sequence s_gap;
    slave_select_n [*4];
  endsequence

  // select-high cycles in mapped mode, saturating
  logic [6:0] hi_cnt_q;
  always_ff @(posedge sys_clk) begin
    if (!resetn || !slave_select_n || !mapped_access_enable) begin
      hi_cnt_q <= 7'h00;
    end else if (hi_cnt_q != 7'h7F) begin
      hi_cnt_q <= hi_cnt_q + 7'h01;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  AST_TX_REQ_ON: assert property (
    tx_empty_flag && tx_empty_dma_req_enable |=> tx_dma_req)
    else $error("tx dma request missing");
  AST_RX_REQ_ON: assert property (
    rx_full_flag && rx_full_dma_req_enable |=> rx_dma_req)
    else $error("rx dma request missing");
  AST_TX_REQ_OFF: assert property (
    !(tx_empty_flag && tx_empty_dma_req_enable) |=> !tx_dma_req)
    else $error("tx dma request stuck");
  AST_RX_REQ_OFF: assert property (
    !(rx_full_flag && rx_full_dma_req_enable) |=> !rx_dma_req)
    else $error("rx dma request stuck");
  AST_SUB_STALL: assert property (
    s_taken ##0 (bus_req.size != HSIZE_WORD) |=> !hready)
    else $error("narrow read served without fetch");
  AST_BUSY_STALL: assert property (
    !hready |-> mapped_access_busy)
    else $error("stall without busy");
  AST_OFF_READY: assert property (
    !mapped_access_enable |=> hready)
    else $error("stall while mapped mode off");
  AST_DESELECT: assert property (
    $fell(mapped_access_enable) |-> ##[1:16] slave_select_n)
    else $error("select not negated on disable");
  AST_BUSY_DONE: assert property (
    $fell(mapped_access_enable) |-> ##[1:100] !mapped_access_busy)
    else $error("busy stuck after disable");
  AST_SEL_GAP: assert property (
    mapped_access_enable && $rose(slave_select_n) |-> s_gap)
    else $error("select gap too short");
  AST_SEL_GAP_LEN: assert property (
    $fell(slave_select_n) && hi_cnt_q > 7'h01 |->
      hi_cnt_q == {1'b0, select_high_time, 2'b00} + 7'h04)
    else $error("select gap length wrong");
  AST_CLK_FRAMED: assert property (
    flash_clk || (|flash_io_oe) |-> !slave_select_n)
    else $error("link active outside frame");
endmodule // qsmr_monitor

bind qsmr_top qsmr_monitor qsmr_monitor_inst (
  .sys_clk, .resetn, .tx_empty_flag, .rx_full_flag,
  .tx_empty_dma_req_enable, .rx_full_dma_req_enable, .tx_dma_req,
  .rx_dma_req, .mapped_access_enable, .mapped_access_busy, .bus_req,
  .hready, .flash_clk, .slave_select_n, .flash_io_oe, .select_high_time
);

// File: dv/qsmr_flash_model.sv
// behavioural quad flash answering continuous reads in xip mode
`timescale 1ns/1ps

module qsmr_flash_model (
  input  wire logic [3:0] io_out,
  input  wire logic       flash_clk,
  input  wire logic       slave_select_n,
  input  wire logic       addr32,
  output logic [3:0]      io_drv,
  output logic [31:0]     cap_addr,
  output logic [7:0]      cap_xip
);
  // ------------------------------------------------------------------
  // frame decode
  // ------------------------------------------------------------------
  int          n = 0;
  int          h;
  int          k;
  logic [31:0] ba;
  logic [7:0]  fb;

  assign h = addr32 ? 4 : 2;
  initial io_drv = 4'h0;

  // new frame restarts the nibble count; already in xip, no command
  always @(negedge slave_select_n) begin
    n = 0;
    cap_addr = 32'h0;
  end

  // released lines show the inverse so stale data cannot pass
  always @(posedge slave_select_n) io_drv = ~io_drv;

  // address then confirmation byte, high nibble first
  always @(posedge flash_clk) begin
    if (!slave_select_n) begin
      if (n < h + 4)
        cap_addr = {cap_addr[27:0], io_out};
      else if (n < h + 6)
        cap_xip = {cap_xip[3:0], io_out};
      n = n + 1;
    end
  end

  // data after four dummy nibbles, set at the fall well before the rise
  always @(negedge flash_clk) begin
    if (!slave_select_n && n >= h + 10) begin
      k = n - h - 10;
      ba = cap_addr + 32'(k / 2);
      fb = ba[7:0] ^ ba[15:8] ^ 8'h3C;
      io_drv = k[0] ? fb[3:0] : fb[7:4];
    end
  end
endmodule // qsmr_flash_model

// File: dv/qsmr_top_test.sv
// self-checking bench of the mapped flash read engine
`timescale 1ns/1ps

module qsmr_top_test
  import qsmr_pkg::*;
;
  // ------------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        tx_empty_flag = 1'b0;
  logic        rx_full_flag = 1'b0;
  logic        tx_empty_dma_req_enable = 1'b0;
  logic        rx_full_dma_req_enable = 1'b0;
  logic        master_select_output = 1'b0;
  logic        mapped_access_enable = 1'b0;
  logic [11:0] flash_remap_base = 12'h000;
  logic        address_width_select = 1'b0;
  logic [7:0]  xip_activation_byte = 8'h00;
  logic [3:0]  select_high_time = 4'h0;
  qsmr_req_s   bus_req = '0;
  logic        tx_dma_req, rx_dma_req, mapped_access_busy, hready;
  logic [31:0] hrdata, cap_addr;
  logic        flash_clk, slave_select_n;
  logic [3:0]  flash_io_in, flash_io_out, flash_io_oe, io_drv;
  logic [7:0]  cap_xip;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [31:0] d;
  int          w;

  // wire level: whoever enables drives the line
  assign flash_io_in = (flash_io_oe & flash_io_out) | (~flash_io_oe & io_drv);

  qsmr_top qsmr_top_inst (
    .sys_clk, .resetn, .tx_empty_flag, .rx_full_flag,
    .tx_empty_dma_req_enable, .rx_full_dma_req_enable, .tx_dma_req,
    .rx_dma_req, .master_select_output, .mapped_access_enable,
    .flash_remap_base, .address_width_select, .xip_activation_byte,
    .select_high_time, .mapped_access_busy, .bus_req, .hready, .hrdata,
    .flash_clk, .slave_select_n, .flash_io_in, .flash_io_out, .flash_io_oe
  );

  qsmr_flash_model qsmr_flash_model_inst (
    .io_out(flash_io_out), .flash_clk, .slave_select_n,
    .addr32(address_width_select), .io_drv, .cap_addr, .cap_xip
  );

  // ------------------------------------------------------------------
  // clock, timeout and helpers
  // ------------------------------------------------------------------
  always #2.5 sys_clk = ~sys_clk;

  // whole run needs well under ten thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // flash content is a pure function of its byte address
  function automatic logic [7:0] fb(input logic [31:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h3C;
  endfunction
  function automatic logic [31:0] fw(input logic [31:0] x);
    return {fb(x + 32'h3), fb(x + 32'h2), fb(x + 32'h1), fb(x)};
  endfunction

  // one read: address phase, then data phase until hready, w counts waits
  task automatic rd(input logic [31:0] a, input logic [2:0] sz);
    bus_req <= '{1'b1, 2'b10, 1'b0, sz, a};
    @(posedge sys_clk);
    bus_req <= '0;
    w = 0;
    @(posedge sys_clk);
    while (hready !== 1'b1 && w < 2000) begin
      w++;
      @(posedge sys_clk);
    end
    d = hrdata;
  endtask

  // word miss, then two sequential hits served from the prefetch
  task automatic seq3(input logic [31:0] b);
    logic [31:0] fa;
    logic [31:0] m;
    fa = {flash_remap_base, b[19:0]};
    m = address_width_select ? 32'hFFFFFFFF : 32'h00FFFFFF;
    rd(b, HSIZE_WORD);
    check("miss_wait", 32'(w > 0), 32'h1);
    check("miss_data", d, fw(fa));
    check("flash_addr", cap_addr & m, fa & m);
    check("xip_byte", 32'(cap_xip), 32'(xip_activation_byte));
    master_select_output <= 1'b0;
    w = 0;
    while (mapped_access_busy !== 1'b0 && w < 2000) begin
      w++;
      @(posedge sys_clk);
    end
    check("busy_idle", 32'(mapped_access_busy), 32'h0);
    check("select_kept", 32'(slave_select_n), 32'h0);
    for (int i = 1; i < 3; i++) begin
      rd(b + ADDR_STEP * i, HSIZE_WORD);
      check("hit_wait", 32'(w), 32'h0);
      check("hit_data", d, fw(fa + ADDR_STEP * i));
    end
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    // every flag and enable combination, request one cycle later
    for (int i = 0; i < 16; i++) begin
      {tx_empty_flag, tx_empty_dma_req_enable} <= 2'(i >> 2);
      {rx_full_flag, rx_full_dma_req_enable} <= 2'(i);
      repeat (2) @(posedge sys_clk);
      check("tx_req", 32'(tx_dma_req), 32'(i[3] & i[2]));
      check("rx_req", 32'(rx_dma_req), 32'(i[1] & i[0]));
    end
    // register-driven reception: dummy writer and drainer channels
    master_select_output <= 1'b1;
    {tx_empty_flag, tx_empty_dma_req_enable} <= 2'b11;
    {rx_full_flag, rx_full_dma_req_enable} <= 2'b01;
    repeat (2) @(posedge sys_clk);
    check("sel_sw", 32'(slave_select_n), 32'h0);
    check("kick_tx", 32'(tx_dma_req), 32'h1);
    check("kick_rx", 32'(rx_dma_req), 32'h0);
    // dummy taken, then a word lands and the buffer frees again
    tx_empty_flag <= 1'b0;
    @(posedge sys_clk);
    {tx_empty_flag, rx_full_flag} <= 2'b11;
    repeat (2) @(posedge sys_clk);
    check("both_rx", 32'(rx_dma_req), 32'h1);
    check("both_tx", 32'(tx_dma_req), 32'h1);
    // drainer served first, its read clears the full flag
    rx_full_flag <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("drain_rx", 32'(rx_dma_req), 32'h0);
    check("drain_tx", 32'(tx_dma_req), 32'h1);
    tx_empty_flag <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("dummy_tx", 32'(tx_dma_req), 32'h0);
    master_select_output <= 1'b0;
    @(posedge sys_clk);
    // mapped off: reads are ignored without stalling
    rd(32'h0000_0040, HSIZE_WORD);
    check("off_wait", 32'(w), 32'h0);
    // software select held from the xip command, then mapped mode
    master_select_output <= 1'b1;
    flash_remap_base <= 12'hA5C;
    xip_activation_byte <= 8'hA7;
    select_high_time <= 4'h3;
    @(posedge sys_clk);
    mapped_access_enable <= 1'b1;
    @(posedge sys_clk);
    seq3(32'h0003_4560);
    seq3(32'h0007_8AB0);
    // narrow reads fetch alone, so the following one misses again
    rd(32'h0001_0000, 3'h0);
    check("byte_wait", 32'(w > 0), 32'h1);
    check("byte_data", 32'(d[7:0]), 32'(fb(32'hA5C1_0000)));
    rd(32'h0001_0004, 3'h1);
    check("half_wait", 32'(w > 0), 32'h1);
    check("half_data", 32'(d[15:0]),
          32'(fw(32'hA5C1_0004) & 32'hFFFF));
    // leave the window, reprogram with 32-bit addressing, come back
    mapped_access_enable <= 1'b0;
    repeat (100) @(posedge sys_clk);
    check("sel_off", 32'(slave_select_n), 32'h1);
    check("busy_off", 32'(mapped_access_busy), 32'h0);
    address_width_select <= 1'b1;
    flash_remap_base <= 12'h3C9;
    master_select_output <= 1'b1;
    @(posedge sys_clk);
    mapped_access_enable <= 1'b1;
    @(posedge sys_clk);
    seq3(32'h000F_FFE0);
    mapped_access_enable <= 1'b0;
    repeat (100) @(posedge sys_clk);
    check("busy_end", 32'(mapped_access_busy), 32'h0);
    finish_test();
  end
endmodule // qsmr_top_test
